//--- common/sscmd_pkg.sv
// Purpose: shared constants and types of the status and state command block
// Assumes: one 20 MHz clock, commands arrive pre-parsed as one-hot codes
// Notes:   firmware revision is coded as major*100+minor (1.13 -> 113)
package sscmd_pkg;
    // one-hot command codes
    typedef enum logic [9:0] {
        SSC_NONE  = 10'h000,
        SSC_OPT_Q = 10'h001,
        SSC_PSC   = 10'h002,
        SSC_PSC_Q = 10'h004,
        SSC_RCL   = 10'h008,
        SSC_SAV   = 10'h010,
        SSC_RST   = 10'h020,
        SSC_SRE   = 10'h040,
        SSC_SRE_Q = 10'h080,
        SSC_STB_Q = 10'h100,
        SSC_DCL   = 10'h200
    } sscmd_cmd_t;

    localparam int          SSC_SLOTS       = 8;
    localparam logic [7:0]  SSC_SLOT_MAX    = 8'h07;
    localparam int          SSC_OPT_N       = 13;
    // option entry positions, in report order
    localparam int          SSC_OPT_AIR_A   = 9;   // aircraft_test_option_a
    localparam int          SSC_OPT_LFLIM   = 10;  // low_freq_limit_option
    localparam int          SSC_OPT_SYSCFG  = 11;  // system_config_option
    localparam int          SSC_OPT_AIR_C   = 12;  // aircraft_test_option_c
    localparam int          SSC_OPT_AIR_B   = 13;  // aircraft_test_option_b (extra table)
    localparam logic [15:0] SSC_REV_AIR_A   = 16'h0071;  // 1.13
    localparam logic [15:0] SSC_REV_LFLIM   = 16'h0072;  // 1.14
    localparam logic [15:0] SSC_REV_LATE    = 16'h0190;  // 4.00
    // status byte bit positions
    localparam int          SSC_STB_OPER    = 7;
    localparam int          SSC_STB_MSS     = 6;
    localparam int          SSC_STB_ESB     = 5;
    localparam int          SSC_STB_MAV     = 4;
    localparam int          SSC_STB_QUES    = 3;
    localparam logic [7:0]  SSC_SRE_RESET   = 8'h00;
    localparam logic [7:0]  SSC_PSC_ON      = 8'h01;
    localparam logic [7:0]  SSC_PSC_OFF     = 8'h00;
    // reset defaults of the instrument state
    localparam logic [15:0] SSC_TRIP_DLY_MS = 16'h0064;  // 100 ms
    localparam logic [15:0] SSC_TRIG_FRQ_HZ = 16'h003C;  // 60 Hz

    typedef struct packed {
        logic        output_on;
        logic        continuous_initiate;
        logic        ttl_trigger_output;
        logic [15:0] overcurrent_trip_delay;
        logic [15:0] triggered_frequency;
        logic        fixed_modes;
        logic        slew_max;
        logic        trigger_source_select;  // 1 = immediate
        logic        trigger_sync_source;    // 1 = immediate
        logic        list_step_mode;         // 1 = auto
        logic        cal_on;
        logic [63:0] transient_list;
    } sscmd_state_t;

    localparam sscmd_state_t SSC_STATE_RST = '{
        output_on: 1'b0, continuous_initiate: 1'b0, ttl_trigger_output: 1'b0,
        overcurrent_trip_delay: SSC_TRIP_DLY_MS, triggered_frequency: SSC_TRIG_FRQ_HZ,
        fixed_modes: 1'b1, slew_max: 1'b1, trigger_source_select: 1'b1,
        trigger_sync_source: 1'b1, list_step_mode: 1'b1, cal_on: 1'b0,
        transient_list: 64'h0};

    // nonvolatile word for the two enable registers
    typedef struct packed {
        logic       psc;
        logic [7:0] sre;
        logic [7:0] ese;
    } sscmd_nv_t;

    // option report: present = entry shown, installed = keyword else 0
    typedef struct packed {
        logic [SSC_OPT_N:0] present;
        logic [SSC_OPT_N:0] installed;
    } sscmd_opt_t;
endpackage : sscmd_pkg

//--- testbench/sscmd_ctrl_model.sv
// Purpose: remote controller model for the status and state command block
// Assumes: requests change just after a rising edge, one command per request
// Notes:   also keeps the nonvolatile enable word, which survives power-off
`timescale 1ns/1ns
`default_nettype none
module sscmd_ctrl_model (
    input  wire logic                 clk,
    input  wire logic                 nv_wr,
    input  wire sscmd_pkg::sscmd_nv_t nv_out,
    output sscmd_pkg::sscmd_cmd_t     cmd,
    output logic [7:0]                arg,
    output logic                      poll,
    output sscmd_pkg::sscmd_nv_t      nv_q
);
    // idle bus; a blank word stands for a unit never configured
    initial begin
        cmd = sscmd_pkg::SSC_NONE;
        arg = 8'h00;
        poll = 1'b0;
        nv_q = '0;
    end
    // nonvolatile word, not reset, so it is read back after power-on
    always @(posedge clk) begin
        if (nv_wr === 1'b1) nv_q <= nv_out;
    end
    // one command per request; returns once the registered answer landed
    task automatic send(input sscmd_pkg::sscmd_cmd_t c, input logic [7:0] a);
        @(posedge clk);
        cmd <= c;
        arg <= a;
        @(posedge clk);
        cmd <= sscmd_pkg::SSC_NONE;
        #1;
    endtask : send
    // serial poll is a single-cycle pulse
    task automatic serial_poll;
        @(posedge clk);
        poll <= 1'b1;
        @(posedge clk);
        poll <= 1'b0;
        #1;
    endtask : serial_poll
endmodule : sscmd_ctrl_model
`default_nettype wire

//--- testbench/sscmd_top_bench.sv
// Purpose: self-checking bench of the status and state command block
// Assumes: commands and polls come from the controller model
// Notes:   power is cycled through the reset input to test restore paths
`timescale 1ns/1ns
`default_nettype none
module sscmd_top_bench;
    logic                    clk = 1'b0;
    logic                    nrst = 1'b0;
    logic [15:0]             fw_rev = 16'h0190;
    logic [13:0]             opt_fitted = 14'h2AAA;
    logic [13:0]             pres;
    logic [7:0]              ev_reg = 8'h00;
    logic [7:0]              ev_mask = 8'h00;
    logic [7:0]              arg, rsp_data, poll_byte, ese_init;
    logic [2:0]              sum_in = 3'h0;  // oper, ques, mav
    logic                    state_load = 1'b0;
    logic                    poll, rsp_valid, rsp_err, srq, clr_status, trig_abort, nv_wr, ese_wr;
    sscmd_pkg::sscmd_state_t state_in = sscmd_pkg::SSC_STATE_RST;
    sscmd_pkg::sscmd_state_t st_out, s;
    sscmd_pkg::sscmd_cmd_t   cmd;
    sscmd_pkg::sscmd_cmd_t   rsts [2] = '{sscmd_pkg::SSC_RST, sscmd_pkg::SSC_DCL};
    sscmd_pkg::sscmd_nv_t    nv_q, nv_out;
    sscmd_pkg::sscmd_opt_t   rsp_opt;
    logic [15:0]             revs [5] = '{16'h0070, 16'h0071, 16'h0072, 16'h018F, 16'h0190};
    int                      failures = 0;
    int                      compares = 0;

    // 50 ns period
    always #25 clk = ~clk;

    sscmd_top i_sscmd_top (.SYS_CLK(clk), .NRST(nrst), .CMD_CODE(cmd), .CMD_ARG(arg),
        .SERIAL_POLL(poll), .FW_REV(fw_rev), .OPT_FITTED(opt_fitted), .OPER_SUM(sum_in[2]),
        .QUES_SUM(sum_in[1]), .MSG_AVAIL(sum_in[0]), .EVENT_REG(ev_reg), .EVENT_MASK(ev_mask),
        .NV_IN(nv_q), .STATE_LOAD(state_load), .STATE_IN(state_in), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .RSP_OPT(rsp_opt), .RSP_ERR(rsp_err), .SRQ(srq),
        .POLL_BYTE(poll_byte), .CLR_STATUS(clr_status), .TRIG_ABORT(trig_abort),
        .NV_WR(nv_wr), .NV_OUT(nv_out), .ESE_INIT(ese_init), .ESE_INIT_WR(ese_wr),
        .STATE_OUT(st_out));
    sscmd_ctrl_model i_sscmd_ctrl_model (.clk(clk), .nv_wr(nv_wr), .nv_out(nv_out),
        .cmd(cmd), .arg(arg), .poll(poll), .nv_q(nv_q));

    task automatic complete_run;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : check_byte
    task automatic check_flags(input logic [13:0] got, input logic [13:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : check_flags
    task automatic check_state(input sscmd_pkg::sscmd_state_t got,
                               input sscmd_pkg::sscmd_state_t exp, input string m);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : check_state
    task automatic cmd_run(input sscmd_pkg::sscmd_cmd_t c, input logic [7:0] a);
        i_sscmd_ctrl_model.send(c, a);
    endtask : cmd_run
    task automatic query(input sscmd_pkg::sscmd_cmd_t c, input logic [7:0] exp);
        cmd_run(c, 8'h00);
        check_byte({7'h00, rsp_valid}, 8'h01, "answer strobe");
        check_byte(rsp_data, exp, "answer data");
    endtask : query
    task automatic refused(input sscmd_pkg::sscmd_cmd_t c, input logic [7:0] a);
        cmd_run(c, a);
        check_byte({7'h00, rsp_err}, 8'h01, "refusal strobe");
    endtask : refused
    task automatic load_state(input sscmd_pkg::sscmd_state_t v);
        @(posedge clk);
        state_in <= v;
        state_load <= 1'b1;
        @(posedge clk);
        state_load <= 1'b0;
    endtask : load_state
    // reset doubles as power-off; twenty cycles low each time
    task automatic power_cycle;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (20) @(posedge clk);
        check_state(st_out, sscmd_pkg::SSC_STATE_RST, "state in reset");
        check_byte({7'h00, clr_status}, 8'h01, "clear in reset");
        nrst <= 1'b1;
        // the boot edge hands the event enable out for one cycle
        @(posedge clk);
        #1;
        check_byte({7'h00, ese_wr}, 8'h01, "event enable load");
        repeat (2) @(posedge clk);
    endtask : power_cycle
    // distinct marked state per slot, calibration left on to see it forced off
    function automatic sscmd_pkg::sscmd_state_t sig(input int i);
        sscmd_pkg::sscmd_state_t v;
        v = sscmd_pkg::SSC_STATE_RST;
        v.output_on = 1'b1;
        v.cal_on = 1'b1;
        v.triggered_frequency = 16'(i + 40);
        v.transient_list = 64'h0123_4567_89AB_CDEF + 64'(i);
        return v;
    endfunction : sig

    // span reckoned as fifty times the expected run length
    initial begin
        #500000;
        failures++;
        complete_run();
    end

    initial begin
        power_cycle();
        query(sscmd_pkg::SSC_SRE_Q, 8'h00);
        // status byte layout with a zero request mask
        @(posedge clk);
        sum_in <= 3'h7;
        ev_reg <= 8'h01;
        ev_mask <= 8'h01;
        query(sscmd_pkg::SSC_STB_Q, 8'hB8);
        query(sscmd_pkg::SSC_STB_Q, 8'hB8);
        @(posedge clk);
        ev_reg <= 8'h00;
        query(sscmd_pkg::SSC_STB_Q, 8'h98);
        check_byte({7'h00, srq}, 8'h00, "no request with zero mask");
        cmd_run(sscmd_pkg::SSC_SRE, 8'h80);
        repeat (2) @(posedge clk);
        #1;
        check_byte({7'h00, srq}, 8'h01, "request raised");
        query(sscmd_pkg::SSC_STB_Q, 8'hD8);
        i_sscmd_ctrl_model.serial_poll();
        check_byte(poll_byte, 8'hD8, "poll byte");
        check_byte({7'h00, srq}, 8'h00, "request cleared by poll");
        query(sscmd_pkg::SSC_STB_Q, 8'hD8);
        i_sscmd_ctrl_model.serial_poll();
        check_byte(poll_byte, 8'h98, "second poll");
        // enables across power cycles under both clear settings
        @(posedge clk);
        ev_mask <= 8'h21;
        sum_in <= 3'h0;
        refused(sscmd_pkg::SSC_PSC, 8'h02);
        cmd_run(sscmd_pkg::SSC_PSC, 8'h00);
        query(sscmd_pkg::SSC_PSC_Q, 8'h00);
        cmd_run(sscmd_pkg::SSC_SRE, 8'h80);
        power_cycle();
        query(sscmd_pkg::SSC_SRE_Q, 8'h80);
        check_byte(ese_init, 8'h21, "event enable restored");
        cmd_run(sscmd_pkg::SSC_PSC, 8'h01);
        power_cycle();
        query(sscmd_pkg::SSC_SRE_Q, 8'h00);
        check_byte(ese_init, 8'h00, "event enable cleared");
        query(sscmd_pkg::SSC_PSC_Q, 8'h01);
        // no slot has been written yet, so a recall of slot 3 is refused
        refused(sscmd_pkg::SSC_RCL, 8'h03);
        check_state(st_out, sscmd_pkg::SSC_STATE_RST, "empty slot kept state");
        // fill every slot, then recall each one
        for (int i = 0; i < 8; i++) begin
            load_state(sig(i));
            cmd_run(sscmd_pkg::SSC_SAV, 8'(i));
        end
        load_state(sscmd_pkg::SSC_STATE_RST);
        for (int i = 0; i < 8; i++) begin
            cmd_run(sscmd_pkg::SSC_RCL, 8'(i));
            check_byte({7'h00, trig_abort}, 8'h01, "abort on recall");
            s = sig(i);
            s.cal_on = 1'b0;
            check_state(st_out, s, "recalled state");
        end
        refused(sscmd_pkg::SSC_SAV, 8'h08);
        refused(sscmd_pkg::SSC_RCL, 8'hFF);
        check_state(st_out, s, "state kept after refusal");
        cmd_run(sscmd_pkg::SSC_RCL, 8'h00);
        s = sig(0);
        s.cal_on = 1'b0;
        check_state(st_out, s, "slot kept after refusal");
        // reset and device clear load defaults but keep the request mask
        foreach (rsts[k]) begin
            cmd_run(sscmd_pkg::SSC_SRE, 8'h28);
            load_state(sig(5));
            cmd_run(rsts[k], 8'h00);
            check_byte({7'h00, clr_status}, 8'h01, "status clear");
            check_state(st_out, sscmd_pkg::SSC_STATE_RST, "defaults");
            query(sscmd_pkg::SSC_SRE_Q, 8'h28);
        end
        // option report across revision thresholds
        foreach (revs[k]) begin
            @(posedge clk);
            fw_rev <= revs[k];
            cmd_run(sscmd_pkg::SSC_OPT_Q, 8'h00);
            pres = 14'h01FF;
            pres[9] = revs[k] >= 16'h0071;
            pres[10] = revs[k] >= 16'h0072;
            pres[13:11] = {3{revs[k] >= 16'h0190}};
            check_flags(rsp_opt.present, pres, "option entries");
            check_flags(rsp_opt.installed & pres, opt_fitted & pres, "option keywords");
        end
        // the option report has no setting form, so no such code is taken
        refused(sscmd_pkg::sscmd_cmd_t'(10'h003), 8'h00);
        complete_run();
    end
endmodule : sscmd_top_bench
`default_nettype wire

//--- verilog/sscmd_slots.sv
// Purpose: eight-slot store of saved instrument states
// Assumes: write and read are taken on the same clock as the caller
// Notes:   slot contents are not reset, only their valid flags are
`timescale 1ns/1ns
`default_nettype none
module sscmd_slots (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   wr_en,
    input  wire logic [2:0]             wr_slot,
    input  wire sscmd_pkg::sscmd_state_t wr_data,
    input  wire logic [2:0]             rd_slot,
    output sscmd_pkg::sscmd_state_t     rd_data,
    output logic                        rd_valid
);
    sscmd_pkg::sscmd_state_t mem [sscmd_pkg::SSC_SLOTS];
    logic [7:0] valid_q;
    logic [7:0] valid_d;

    // a slot becomes readable once it has been written
    always_comb begin
        valid_d = valid_q;
        if (wr_en) begin
            valid_d[wr_slot] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 8'h00;
        end else begin
            valid_q <= valid_d;
        end
    end

    // storage array, no reset so it maps onto memory
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_slot] <= wr_data;
        end
    end

    assign rd_data  = mem[rd_slot];
    assign rd_valid = valid_q[rd_slot];
endmodule : sscmd_slots
`default_nettype wire

//--- verilog/sscmd_top.sv
// Purpose: common status and state commands of a programmable AC/DC source
// Assumes: parser delivers one-hot commands with a numeric argument
// Notes:   enables persist through an external nonvolatile word while power-on clear is off
`timescale 1ns/1ns
`default_nettype none
module sscmd_top (
    input  wire logic                    SYS_CLK,
    input  wire logic                    NRST,
    input  wire sscmd_pkg::sscmd_cmd_t   CMD_CODE,
    input  wire logic [7:0]              CMD_ARG,
    input  wire logic                    SERIAL_POLL,
    input  wire logic [15:0]             FW_REV,
    input  wire logic [13:0]             OPT_FITTED,
    input  wire logic                    OPER_SUM,
    input  wire logic                    QUES_SUM,
    input  wire logic                    MSG_AVAIL,
    input  wire logic [7:0]              EVENT_REG,
    input  wire logic [7:0]              EVENT_MASK,
    input  wire sscmd_pkg::sscmd_nv_t    NV_IN,
    input  wire logic                    STATE_LOAD,
    input  wire sscmd_pkg::sscmd_state_t STATE_IN,
    output logic                         RSP_VALID,
    output logic [7:0]                   RSP_DATA,
    output sscmd_pkg::sscmd_opt_t        RSP_OPT,
    output logic                         RSP_ERR,
    output logic                         SRQ,
    output logic [7:0]                   POLL_BYTE,
    output logic                         CLR_STATUS,
    output logic                         TRIG_ABORT,
    output logic                         NV_WR,
    output sscmd_pkg::sscmd_nv_t         NV_OUT,
    output logic [7:0]                   ESE_INIT,
    output logic                         ESE_INIT_WR,
    output sscmd_pkg::sscmd_state_t      STATE_OUT
);
    sscmd_pkg::sscmd_state_t state_q, state_d, slot_rd;
    sscmd_pkg::sscmd_opt_t   opt_q, opt_d;
    logic [7:0] sre_q, sre_d, rsp_data_q, rsp_data_d, poll_q, poll_d;
    logic [7:0] nv_ese_q, nv_ese_d, stb;
    logic       psc_q, psc_d, boot_q, boot_d, rqs_q, rqs_d, mss_prev_q;
    logic       rsp_valid_q, rsp_valid_d, err_q, err_d;
    logic       clr_q, clr_d, abort_q, abort_d, nvwr_q, nvwr_d;
    logic       esewr_q, esewr_d, mss, slot_ok, slot_valid, sav_en;

    // slot range check shared by save and recall
    function automatic logic slot_in_range(input logic [7:0] arg);
        return arg <= sscmd_pkg::SSC_SLOT_MAX;
    endfunction : slot_in_range

    // late option gate: entry hidden when firmware is too old
    function automatic logic rev_ok(input logic [15:0] rev, input logic [15:0] min);
        return rev >= min;
    endfunction : rev_ok

    // live status byte; bit 6 holds the master summary
    always_comb begin
        stb = 8'h00;
        stb[sscmd_pkg::SSC_STB_OPER] = OPER_SUM;
        stb[sscmd_pkg::SSC_STB_ESB]  = |(EVENT_REG & EVENT_MASK);
        stb[sscmd_pkg::SSC_STB_MAV]  = MSG_AVAIL;
        stb[sscmd_pkg::SSC_STB_QUES] = QUES_SUM;
        // summaries follow their sources, so they drop only when those are read
        mss = |(stb & sre_q);
        stb[sscmd_pkg::SSC_STB_MSS] = mss;
    end

    assign slot_ok = slot_in_range(CMD_ARG);
    assign sav_en  = (CMD_CODE == sscmd_pkg::SSC_SAV) && slot_ok && !boot_q;

    sscmd_slots u_slots (
        .clk      (SYS_CLK),
        .rst_n    (NRST),
        .wr_en    (sav_en),
        .wr_slot  (CMD_ARG[2:0]),
        .wr_data  (state_q),
        .rd_slot  (CMD_ARG[2:0]),
        .rd_data  (slot_rd),
        .rd_valid (slot_valid)
    );

    // command decode; first cycle after power-on restores the enables, or clears them when power-on clear is set
    always_comb begin
        state_d     = state_q;
        sre_d       = sre_q;
        psc_d       = psc_q;
        nv_ese_d    = nv_ese_q;
        boot_d      = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_data_d  = rsp_data_q;
        opt_d       = opt_q;
        err_d       = 1'b0;
        clr_d       = 1'b0;
        abort_d     = 1'b0;
        nvwr_d      = 1'b0;
        esewr_d     = 1'b0;
        if (boot_q) begin
            psc_d   = NV_IN.psc;
            esewr_d = 1'b1;
            if (NV_IN.psc) begin
                sre_d    = sscmd_pkg::SSC_SRE_RESET;
                nv_ese_d = sscmd_pkg::SSC_SRE_RESET;
            end else begin
                sre_d    = NV_IN.sre;
                nv_ese_d = NV_IN.ese;
            end
        end else begin
            if (STATE_LOAD) begin
                state_d = STATE_IN;
            end
            case (CMD_CODE)
                sscmd_pkg::SSC_NONE: begin
                end
                sscmd_pkg::SSC_OPT_Q: begin
                    // query only: no setting code exists for options
                    rsp_valid_d         = 1'b1;
                    opt_d.installed     = OPT_FITTED;
                    opt_d.present       = '1;
                    opt_d.present[sscmd_pkg::SSC_OPT_AIR_A] =
                        rev_ok(FW_REV, sscmd_pkg::SSC_REV_AIR_A);
                    opt_d.present[sscmd_pkg::SSC_OPT_LFLIM] =
                        rev_ok(FW_REV, sscmd_pkg::SSC_REV_LFLIM);
                    opt_d.present[sscmd_pkg::SSC_OPT_SYSCFG] =
                        rev_ok(FW_REV, sscmd_pkg::SSC_REV_LATE);
                    opt_d.present[sscmd_pkg::SSC_OPT_AIR_C] =
                        rev_ok(FW_REV, sscmd_pkg::SSC_REV_LATE);
                    opt_d.present[sscmd_pkg::SSC_OPT_AIR_B] =
                        rev_ok(FW_REV, sscmd_pkg::SSC_REV_LATE);
                end
                sscmd_pkg::SSC_PSC: begin
                    // parser maps OFF to 0 and ON to 1
                    if (CMD_ARG == sscmd_pkg::SSC_PSC_ON || CMD_ARG == sscmd_pkg::SSC_PSC_OFF) begin
                        psc_d  = CMD_ARG[0];
                        nvwr_d = 1'b1;
                    end else begin
                        err_d = 1'b1;
                    end
                end
                sscmd_pkg::SSC_PSC_Q: begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d  = {7'h00, psc_q};
                end
                sscmd_pkg::SSC_RCL: begin
                    if (slot_ok && slot_valid) begin
                        state_d        = slot_rd;
                        state_d.cal_on = 1'b0;
                        abort_d        = 1'b1;
                    end else begin
                        err_d = 1'b1;
                    end
                end
                sscmd_pkg::SSC_SAV: begin
                    err_d = !slot_ok;
                end
                sscmd_pkg::SSC_RST, sscmd_pkg::SSC_DCL: begin
                    // enables are untouched so they survive a reset
                    state_d = sscmd_pkg::SSC_STATE_RST;
                    clr_d   = 1'b1;
                end
                sscmd_pkg::SSC_SRE: begin
                    sre_d  = CMD_ARG;
                    nvwr_d = 1'b1;
                end
                sscmd_pkg::SSC_SRE_Q: begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d  = sre_q;
                end
                sscmd_pkg::SSC_STB_Q: begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d  = stb;
                end
                default: begin
                    err_d = 1'b1;
                end
            endcase
        end
    end

    // request for service: set on a new reason, cleared by a serial poll
    always_comb begin
        rqs_d  = rqs_q;
        poll_d = poll_q;
        if (SERIAL_POLL) begin
            rqs_d  = 1'b0;
            poll_d = {stb[7], rqs_q, stb[5:0]};
        end
        // a rising summary in the poll cycle still sets, so no request is lost
        if (mss && !mss_prev_q) begin
            rqs_d = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q     <= sscmd_pkg::SSC_STATE_RST;
            sre_q       <= sscmd_pkg::SSC_SRE_RESET;
            psc_q       <= 1'b0;
            nv_ese_q    <= 8'h00;
            boot_q      <= 1'b1;
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= 8'h00;
            opt_q       <= '0;
            err_q       <= 1'b0;
            clr_q       <= 1'b1;
            abort_q     <= 1'b0;
            nvwr_q      <= 1'b0;
            esewr_q     <= 1'b0;
            rqs_q       <= 1'b0;
            mss_prev_q  <= 1'b0;
            poll_q      <= 8'h00;
        end else begin
            state_q     <= state_d;
            sre_q       <= sre_d;
            psc_q       <= psc_d;
            nv_ese_q    <= nv_ese_d;
            boot_q      <= boot_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q  <= rsp_data_d;
            opt_q       <= opt_d;
            err_q       <= err_d;
            clr_q       <= clr_d;
            abort_q     <= abort_d;
            nvwr_q      <= nvwr_d;
            esewr_q     <= esewr_d;
            rqs_q       <= rqs_d;
            mss_prev_q  <= mss;
            poll_q      <= poll_d;
        end
    end

    assign RSP_VALID   = rsp_valid_q;
    assign RSP_DATA    = rsp_data_q;
    assign RSP_OPT     = opt_q;
    assign RSP_ERR     = err_q;
    assign SRQ         = rqs_q;
    assign POLL_BYTE   = poll_q;
    assign CLR_STATUS  = clr_q;
    assign TRIG_ABORT  = abort_q;
    assign NV_WR       = nvwr_q;
    assign NV_OUT      = '{psc: psc_q, sre: sre_q, ese: EVENT_MASK};
    assign ESE_INIT    = nv_ese_q;
    assign ESE_INIT_WR = esewr_q;
    assign STATE_OUT   = state_q;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    sequence s_poll_taken;
        SERIAL_POLL && !(mss && !mss_prev_q);
    endsequence

    sequence s_good_recall;
        !boot_q && CMD_CODE == sscmd_pkg::SSC_RCL && slot_ok && slot_valid && !STATE_LOAD;
    endsequence

    a_poll_clears_rqs: assert property (s_poll_taken |=> !SRQ)
        else $error("serial poll left the service request set");
    a_poll_byte_rqs: assert property (SERIAL_POLL |=> POLL_BYTE[6] == $past(rqs_q))
        else $error("poll byte bit 6 is not the request bit");
    a_zero_mask_quiet: assert property (sre_q == 8'h00 && !SRQ |=> !SRQ)
        else $error("service request raised with a zero mask");
    a_mss_gating: assert property (mss && !mss_prev_q |=> SRQ)
        else $error("enabled summary did not raise a request");
    a_recall_cal_off: assert property (s_good_recall |=> !STATE_OUT.cal_on && TRIG_ABORT)
        else $error("recall left calibration on or skipped abort");
    a_bad_slot_err: assert property (!boot_q && (CMD_CODE == sscmd_pkg::SSC_SAV ||
        CMD_CODE == sscmd_pkg::SSC_RCL) && !slot_ok && !STATE_LOAD
        |=> RSP_ERR && $stable(STATE_OUT))
        else $error("out of range slot was not refused");
    a_rst_defaults: assert property (!boot_q && CMD_CODE == sscmd_pkg::SSC_RST
        |=> STATE_OUT == sscmd_pkg::SSC_STATE_RST && CLR_STATUS && $stable(sre_q))
        else $error("reset did not load defaults or touched the mask");
    a_psc_boot_clear: assert property (boot_q && NV_IN.psc
        |=> sre_q == 8'h00 && ESE_INIT == 8'h00 && ESE_INIT_WR)
        else $error("enables not cleared at power-on");
    a_stb_query_keep: assert property (!boot_q && CMD_CODE == sscmd_pkg::SSC_STB_Q && !SERIAL_POLL
        |=> RSP_VALID && SRQ == $past(rqs_q) | $past(mss && !mss_prev_q))
        else $error("status byte query disturbed the request bit");
    a_opt_gate: assert property (!boot_q && CMD_CODE == sscmd_pkg::SSC_OPT_Q
        && FW_REV < sscmd_pkg::SSC_REV_AIR_A |=> !RSP_OPT.present[sscmd_pkg::SSC_OPT_AIR_A])
        else $error("option entry shown on old firmware");
endmodule : sscmd_top
`default_nettype wire
